// ### rtl/icsc_core.v
// Combat state controller for an infrared battle vehicle
//
// Functional notes
// - Each setup tap steps light, middle, heavy, test, off; effective at once.
// - Each setup press pulses an announcement carrying the newly chosen setting.
// - Test setting: any infrared activity counts as a hit, unchecked.
// - Off setting: no hits, caps, destruction or combat timers.
// - Normal settings accept only hits the protocol decoder marks valid.
// - Slight cap after first hit; strong at 3/2/4/5 hits (test/light/middle/heavy).
// - Caps only lower top speed; they never stop motion.
// - Destroyed with explosion at 6/3/6/9 hits.
// - Destroyed: drive and weapon blocked until resurrection, 5 s test, else 15 s.
// - Resurrection pulses fanfare, then hits ignored 2/15/12/10 s.
// - Shot blocks firing for 3/3/5/9 s, then reload-complete pulse.
// - Accepted hit pulses impact and blocks driving for two seconds.
// - After power-up sensor LED blinks once, the light count of 4/1/2/3, as reset always selects light.
`timescale 1ns/1ps
`default_nettype none
`include "icsc_regs.vh"
module icsc_core #(
  parameter integer SEC_CYC = `ICSC_SEC_CYC, // Cycles per second, shorten in simulation
  parameter integer DEB_CYC = `ICSC_DEB_CYC  // Setup button debounce cycles
) (
  input  wire       clk,           // System clock, 50 MHz
  input  wire       rstn,          // Async reset, active low
  input  wire       setup_btn,     // Setup button pin, high when pressed
  input  wire       ir_any,        // Sensor raw activity pin, high on any IR
  input  wire       ir_valid,      // Sensor protocol-valid hit pin
  input  wire       fire_req,      // Main gun request, same clock, pulse
  output reg  [2:0] mode_r,        // Current combat setting
  output reg        announce_r,    // Announce setting pulse
  output reg  [1:0] speed_cap_r,   // Top speed cap code
  output reg        drive_en_r,    // Drive commands honoured
  output reg        weapon_en_r,   // Weapon commands honoured
  output reg        destroyed_r,   // Vehicle destroyed
  output reg        invuln_r,      // Hits ignored
  output reg        impact_r,      // Impact sound pulse
  output reg        explode_r,     // Explosion sound pulse
  output reg        fanfare_r,     // Fanfare sound pulse
  output reg        reload_done_r, // Reload complete sound pulse
  output reg        ir_tx_r,       // Transmitter trigger pulse
  output reg        sensor_led_r   // Sensor indicator LED
);

  // ----------------------------------------------------------------
  // Per-setting lookups
  // ----------------------------------------------------------------
  function [3:0] strong_lim(input [2:0] m);
    case (m)
      `ICSC_M_TEST:   strong_lim = `ICSC_STRONG_TEST;
      `ICSC_M_MIDDLE: strong_lim = `ICSC_STRONG_MIDDLE;
      `ICSC_M_HEAVY:  strong_lim = `ICSC_STRONG_HEAVY;
      default:        strong_lim = `ICSC_STRONG_LIGHT;
    endcase
  endfunction

  function [3:0] dest_lim(input [2:0] m);
    case (m)
      `ICSC_M_TEST:   dest_lim = `ICSC_DEST_TEST;
      `ICSC_M_MIDDLE: dest_lim = `ICSC_DEST_MIDDLE;
      `ICSC_M_HEAVY:  dest_lim = `ICSC_DEST_HEAVY;
      default:        dest_lim = `ICSC_DEST_LIGHT;
    endcase
  endfunction

  function [3:0] reload_s(input [2:0] m);
    case (m)
      `ICSC_M_TEST:   reload_s = `ICSC_RELOAD_TEST;
      `ICSC_M_MIDDLE: reload_s = `ICSC_RELOAD_MIDDLE;
      `ICSC_M_HEAVY:  reload_s = `ICSC_RELOAD_HEAVY;
      default:        reload_s = `ICSC_RELOAD_LIGHT;
    endcase
  endfunction

  function [3:0] invul_s(input [2:0] m);
    case (m)
      `ICSC_M_TEST:   invul_s = `ICSC_INVUL_TEST;
      `ICSC_M_MIDDLE: invul_s = `ICSC_INVUL_MIDDLE;
      `ICSC_M_HEAVY:  invul_s = `ICSC_INVUL_HEAVY;
      default:        invul_s = `ICSC_INVUL_LIGHT;
    endcase
  endfunction

  function [3:0] resur_s(input [2:0] m);
    case (m)
      `ICSC_M_TEST:   resur_s = `ICSC_RESUR_TEST;
      `ICSC_M_MIDDLE: resur_s = `ICSC_RESUR_MIDDLE;
      `ICSC_M_HEAVY:  resur_s = `ICSC_RESUR_HEAVY;
      default:        resur_s = `ICSC_RESUR_LIGHT;
    endcase
  endfunction

  function [2:0] blinks(input [2:0] m);
    case (m)
      `ICSC_M_TEST:   blinks = `ICSC_BLINK_TEST;
      `ICSC_M_MIDDLE: blinks = `ICSC_BLINK_MIDDLE;
      `ICSC_M_HEAVY:  blinks = `ICSC_BLINK_HEAVY;
      `ICSC_M_OFF:    blinks = 3'h0;
      default:        blinks = `ICSC_BLINK_LIGHT;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  reg [1:0]  btn_s_r, any_s_r, val_s_r;
  reg        any_d_r, val_d_r, btn_st_r;
  reg [31:0] deb_r;

  // Second stage alone feeds the logic; first stage may be metastable
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      btn_s_r <= 2'h0;
      any_s_r <= 2'h0;
      val_s_r <= 2'h0;
      any_d_r <= 1'b0;
      val_d_r <= 1'b0;
    end else begin
      btn_s_r <= {btn_s_r[0], setup_btn};
      any_s_r <= {any_s_r[0], ir_any};
      val_s_r <= {val_s_r[0], ir_valid};
      any_d_r <= any_s_r[1];
      val_d_r <= val_s_r[1];
    end
  end

  // Debounce: button state changes only after a stable level for DEB_CYC
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      deb_r    <= 32'h0;
      btn_st_r <= 1'b0;
    end else if (btn_s_r[1] == btn_st_r) begin
      deb_r <= 32'h0;
    end else if (deb_r == DEB_CYC - 1) begin
      deb_r    <= 32'h0;
      btn_st_r <= btn_s_r[1];
    end else begin
      deb_r <= deb_r + 32'h1;
    end
  end

  wire tap     = btn_s_r[1] && !btn_st_r && (deb_r == DEB_CYC - 1);
  wire combat  = (mode_r != `ICSC_M_OFF);
  wire any_edg = any_s_r[1] && !any_d_r;
  wire val_edg = val_s_r[1] && !val_d_r;
  // Test setting takes raw activity, others only decoded frames
  wire hit_raw = (mode_r == `ICSC_M_TEST) ? any_edg : val_edg;
  wire hit_ok  = combat && hit_raw && !destroyed_r && !invuln_r;
  reg  [3:0] hits_r;
  wire [3:0] hits_nxt = hits_r + 4'h1;
  wire       kill     = hit_ok && (hits_nxt >= dest_lim(mode_r));

  // ----------------------------------------------------------------
  // Timers
  // ----------------------------------------------------------------
  wire rl_busy, rl_done, st_busy, rs_busy, rs_done, iv_busy;
  wire shot = fire_req && weapon_en_r;
  wire stop = !combat;

  icsc_sec_timer #(.SEC_CYC(SEC_CYC)) u_reload (
    .clk(clk), .rstn(rstn), .start(shot), .abort(stop),
    .secs(reload_s(mode_r)), .busy_r(rl_busy), .done_r(rl_done));
  icsc_sec_timer #(.SEC_CYC(SEC_CYC)) u_still (
    .clk(clk), .rstn(rstn), .start(hit_ok), .abort(stop),
    .secs(`ICSC_STILL_S), .busy_r(st_busy), .done_r());
  icsc_sec_timer #(.SEC_CYC(SEC_CYC)) u_resur (
    .clk(clk), .rstn(rstn), .start(kill), .abort(stop),
    .secs(resur_s(mode_r)), .busy_r(rs_busy), .done_r(rs_done));
  icsc_sec_timer #(.SEC_CYC(SEC_CYC)) u_invul (
    .clk(clk), .rstn(rstn), .start(rs_done), .abort(stop),
    .secs(invul_s(mode_r)), .busy_r(iv_busy), .done_r());

  // ----------------------------------------------------------------
  // Combat state
  // ----------------------------------------------------------------
  // Setting changes keep the hit count; leaving combat wipes it
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mode_r        <= `ICSC_M_RESET;
      announce_r    <= 1'b0;
      hits_r        <= 4'h0;
      speed_cap_r   <= `ICSC_CAP_NONE;
      destroyed_r   <= 1'b0;
      impact_r      <= 1'b0;
      explode_r     <= 1'b0;
      fanfare_r     <= 1'b0;
      reload_done_r <= 1'b0;
      ir_tx_r       <= 1'b0;
    end else begin
      announce_r    <= tap;
      impact_r      <= hit_ok;
      explode_r     <= kill;
      fanfare_r     <= rs_done && combat;
      reload_done_r <= rl_done && combat;
      ir_tx_r       <= shot;
      if (tap) begin
        mode_r <= (mode_r == `ICSC_M_OFF) ? `ICSC_M_LIGHT : mode_r + 3'h1;
      end
      if (!combat || rs_done) begin
        hits_r      <= 4'h0;
        speed_cap_r <= `ICSC_CAP_NONE;
        destroyed_r <= 1'b0;
      end else begin
        if (hit_ok) begin
          hits_r <= hits_nxt;
        end
        // Cap tracks the count so a setting change re-grades it at once
        if (hits_r >= strong_lim(mode_r)) begin
          speed_cap_r <= `ICSC_CAP_STRONG;
        end else if (hits_r >= `ICSC_SLIGHT_HITS) begin
          speed_cap_r <= `ICSC_CAP_SLIGHT;
        end else begin
          speed_cap_r <= `ICSC_CAP_NONE;
        end
        if (kill) begin
          destroyed_r <= 1'b1;
        end
      end
    end
  end

  // Command gates and invulnerability flag
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      drive_en_r  <= 1'b1;
      weapon_en_r <= 1'b0;
      invuln_r    <= 1'b0;
    end else begin
      drive_en_r  <= !(combat && (kill || destroyed_r || hit_ok || st_busy));
      weapon_en_r <= combat && !kill && !destroyed_r && !shot && !rl_busy && !rs_busy;
      invuln_r    <= combat && (rs_done || iv_busy);
    end
  end

  // ----------------------------------------------------------------
  // Power-up blinking of the sensor LED
  // ----------------------------------------------------------------
  reg        bl_init_r;
  reg [2:0]  bl_left_r;
  reg [31:0] bl_cyc_r;

  // Count is taken once after reset release, from the reset setting
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bl_init_r    <= 1'b1;
      bl_left_r    <= 3'h0;
      bl_cyc_r     <= 32'h0;
      sensor_led_r <= 1'b0;
    end else if (bl_init_r) begin
      bl_init_r <= 1'b0;
      bl_left_r <= blinks(mode_r);
    end else if (bl_left_r != 3'h0) begin
      if (bl_cyc_r == (SEC_CYC / 2) - 1) begin
        bl_cyc_r     <= 32'h0;
        sensor_led_r <= !sensor_led_r;
        if (sensor_led_r) begin
          bl_left_r <= bl_left_r - 3'h1;
        end
      end else begin
        bl_cyc_r <= bl_cyc_r + 32'h1;
      end
    end else begin
      sensor_led_r <= invuln_r;
    end
  end

endmodule // icsc_core
`default_nettype wire

// ### rtl/icsc_regs.vh
// Constants of the infrared combat state controller
`ifndef ICSC_REGS_VH
`define ICSC_REGS_VH

// ----------------------------------------------------------------
// Clock and time base
// ----------------------------------------------------------------
`define ICSC_CLK_HZ         50000000
`define ICSC_SEC_CYC        (`ICSC_CLK_HZ * 1)
`define ICSC_DEB_MS         20
`define ICSC_DEB_CYC        ((`ICSC_CLK_HZ / 1000) * `ICSC_DEB_MS)
`define ICSC_STILL_S        4'h2
`define ICSC_BLINK_HALF_CYC (`ICSC_SEC_CYC / 2)

// ----------------------------------------------------------------
// Combat settings, in tap order
// ----------------------------------------------------------------
`define ICSC_M_LIGHT        3'h0
`define ICSC_M_MIDDLE       3'h1
`define ICSC_M_HEAVY        3'h2
`define ICSC_M_TEST         3'h3
`define ICSC_M_OFF          3'h4
`define ICSC_M_RESET        3'h0

// ----------------------------------------------------------------
// Speed cap codes
// ----------------------------------------------------------------
`define ICSC_CAP_NONE       2'h0
`define ICSC_CAP_SLIGHT     2'h1
`define ICSC_CAP_STRONG     2'h2

// ----------------------------------------------------------------
// Per-setting figures: test, light, middle, heavy
// ----------------------------------------------------------------
`define ICSC_SLIGHT_HITS    4'h1
`define ICSC_STRONG_TEST    4'h3
`define ICSC_STRONG_LIGHT   4'h2
`define ICSC_STRONG_MIDDLE  4'h4
`define ICSC_STRONG_HEAVY   4'h5
`define ICSC_DEST_TEST      4'h6
`define ICSC_DEST_LIGHT     4'h3
`define ICSC_DEST_MIDDLE    4'h6
`define ICSC_DEST_HEAVY     4'h9
`define ICSC_RELOAD_TEST    4'h3
`define ICSC_RELOAD_LIGHT   4'h3
`define ICSC_RELOAD_MIDDLE  4'h5
`define ICSC_RELOAD_HEAVY   4'h9
`define ICSC_INVUL_TEST     4'h2
`define ICSC_INVUL_LIGHT    4'hF
`define ICSC_INVUL_MIDDLE   4'hC
`define ICSC_INVUL_HEAVY    4'hA
`define ICSC_RESUR_TEST     4'h5
`define ICSC_RESUR_LIGHT    4'hF
`define ICSC_RESUR_MIDDLE   4'hF
`define ICSC_RESUR_HEAVY    4'hF
`define ICSC_BLINK_TEST     3'h4
`define ICSC_BLINK_LIGHT    3'h1
`define ICSC_BLINK_MIDDLE   3'h2
`define ICSC_BLINK_HEAVY    3'h3

`endif

// ### rtl/icsc_sec_timer.v
// Whole-second down timer with start, abort, busy and done pulse
`timescale 1ns/1ps
`default_nettype none
module icsc_sec_timer #(
  parameter integer SEC_CYC = 50000000
) (
  input  wire       clk,    // System clock
  input  wire       rstn,   // Async reset, active low
  input  wire       start,  // Load and run, one-cycle pulse
  input  wire       abort,  // Stop without done
  input  wire [3:0] secs,   // Seconds to run
  output reg        busy_r, // Timer running
  output reg        done_r  // One-cycle pulse at expiry
);

  reg [31:0] cyc_r;
  reg [3:0]  sec_r;

  // ----------------------------------------------------------------
  // Counting
  // ----------------------------------------------------------------
  // Start restarts the whole count, so a new event gets full time unless abort is high in the same cycle, which wins
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cyc_r  <= 32'h0;
      sec_r  <= 4'h0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (abort) begin
        busy_r <= 1'b0;
      end else if (start) begin
        cyc_r  <= 32'h0;
        sec_r  <= secs;
        busy_r <= (secs != 4'h0);
        done_r <= (secs == 4'h0);
      end else if (busy_r) begin
        if (cyc_r == SEC_CYC - 1) begin
          cyc_r <= 32'h0;
          sec_r <= sec_r - 4'h1;
          if (sec_r == 4'h1) begin
            busy_r <= 1'b0;
            done_r <= 1'b1;
          end
        end else begin
          cyc_r <= cyc_r + 32'h1;
        end
      end
    end
  end

endmodule // icsc_sec_timer
`default_nettype wire

// ### tb/icsc_core_sva.sv
// Concurrent checks on the combat state controller ports
`timescale 1ns/1ps
`default_nettype none
`include "icsc_regs.vh"
module icsc_core_sva #(
  parameter integer SEC_CYC = 20
) (
  input wire logic       clk,           // Clock
  input wire logic       rstn,          // Reset, active low
  input wire logic       fire_req,      // Gun request
  input wire logic [2:0] mode_r,        // Setting
  input wire logic       announce_r,    // Announce pulse
  input wire logic [1:0] speed_cap_r,   // Speed cap
  input wire logic       drive_en_r,    // Drive allowed
  input wire logic       weapon_en_r,   // Shot allowed
  input wire logic       destroyed_r,   // Destroyed
  input wire logic       invuln_r,      // Hits ignored
  input wire logic       impact_r,      // Impact pulse
  input wire logic       explode_r,     // Explosion pulse
  input wire logic       fanfare_r,     // Fanfare pulse
  input wire logic       reload_done_r, // Reload pulse
  input wire logic       ir_tx_r        // Transmitter pulse
);
  // ------------------------------------------------
  // Stand-still counter
  // ------------------------------------------------
  // Saturates so a long quiet stretch never wraps into a false window
  logic [31:0] still_r;
  always @(posedge clk or negedge rstn) begin
    if (!rstn) still_r <= 32'hFFFFFFFF;
    else if (impact_r) still_r <= 32'h0;
    else if (still_r != 32'hFFFFFFFF) still_r <= still_r + 32'h1;
  end
  // ------------------------------------------------
  // Checks
  // ------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  a_tap_order: assert property (announce_r |->
    mode_r == (($past(mode_r) == `ICSC_M_OFF) ? `ICSC_M_LIGHT : $past(mode_r) + 3'h1)) else $error("bad setting step");
  a_off_quiet: assert property ((mode_r == `ICSC_M_OFF && $past(mode_r) == `ICSC_M_OFF) |->
    !(impact_r | explode_r | fanfare_r | reload_done_r | ir_tx_r | destroyed_r) && speed_cap_r == 2'h0)
    else $error("combat active while off");
  a_stand_still: assert property ((still_r < 2 * SEC_CYC - 2) |-> !drive_en_r)
    else $error("drive back too early after hit");
  a_fire_tx: assert property ((fire_req && weapon_en_r) |=> ir_tx_r && !weapon_en_r)
    else $error("allowed shot not sent");
  a_fire_blocked: assert property ((fire_req && !weapon_en_r) |=> !ir_tx_r)
    else $error("blocked shot sent");
  a_reload_end: assert property ((reload_done_r && !destroyed_r && mode_r != `ICSC_M_OFF) |=> weapon_en_r)
    else $error("weapon not back after reload");
  a_explode_dest: assert property (explode_r |-> destroyed_r && impact_r)
    else $error("explosion without destruction");
  a_dead_blocked: assert property (destroyed_r |-> !drive_en_r && !weapon_en_r)
    else $error("commands honoured while destroyed");
  a_fanfare_clear: assert property (fanfare_r |=> !destroyed_r && invuln_r && speed_cap_r == 2'h0)
    else $error("resurrection did not clear");
  a_invuln_deaf: assert property (invuln_r |=> !impact_r)
    else $error("hit taken while invulnerable");
  a_cap_first: assert property ((impact_r && !explode_r) |-> ##[1:2] speed_cap_r != 2'h0)
    else $error("no cap after hit");
  c_explode: cover property (explode_r);
  c_fanfare: cover property (fanfare_r);
  c_reload: cover property (reload_done_r);
  c_off: cover property (announce_r && mode_r == `ICSC_M_OFF);
endmodule // icsc_core_sva
bind icsc_core icsc_core_sva #(.SEC_CYC(SEC_CYC)) i_icsc_core_sva (.clk(clk), .rstn(rstn), .fire_req(fire_req),
  .mode_r(mode_r), .announce_r(announce_r), .speed_cap_r(speed_cap_r), .drive_en_r(drive_en_r),
  .weapon_en_r(weapon_en_r), .destroyed_r(destroyed_r), .invuln_r(invuln_r), .impact_r(impact_r),
  .explode_r(explode_r), .fanfare_r(fanfare_r), .reload_done_r(reload_done_r), .ir_tx_r(ir_tx_r));
`default_nettype wire

// ### tb/icsc_ir_sensor_model.sv
// Behavioural infrared hit sensor driving the controller's sensor pins
`timescale 1ns/1ps
`default_nettype none
module icsc_ir_sensor_model (
  input  wire logic clk,     // Clock
  input  wire logic strike,  // Infrared light on the dome
  input  wire logic coded,   // Light carries a valid combat code
  output var  logic ir_any,  // Raw activity, idles low
  output var  logic ir_valid // Decoded hit, idles low
);
  // One clock of lag stands in for the sensor's own filter; single driver per pin
  always @(posedge clk) begin
    ir_any <= strike;
    ir_valid <= strike & coded;
  end
endmodule // icsc_ir_sensor_model
`default_nettype wire

// ### tb/icsc_core_tb.sv
// Self-checking bench of the combat state controller
`timescale 1ns/1ps
`default_nettype none
`include "icsc_regs.vh"
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin failures++; \
  $display("unexpected at %0t: got %0h want %0h", $time, got, exp); end end
module icsc_core_tb;
  localparam integer SEC = 20;
  localparam integer DEB = 4;
  logic clk, rstn, setup_btn, fire_req, strike, coded, prev;
  wire ir_any, ir_valid, announce_r, drive_en_r, weapon_en_r, destroyed_r, invuln_r;
  wire impact_r, explode_r, fanfare_r, reload_done_r, ir_tx_r, sensor_led_r;
  wire [2:0] mode_r;
  wire [1:0] speed_cap_r;
  int failures, tests_run, m, h, k, b;
  int strong_t[4], dest_t[4], reload_t[4], resur_t[4], invul_t[4];
  time t0, t_ev;
  logic [8:0] notes[$];
  logic [8:0] expv;
  logic [5:0] ev;
  logic [31:0] seed;
  icsc_core #(.SEC_CYC(SEC), .DEB_CYC(DEB)) i_icsc_core (.clk(clk), .rstn(rstn), .setup_btn(setup_btn),
    .ir_any(ir_any), .ir_valid(ir_valid), .fire_req(fire_req), .mode_r(mode_r), .announce_r(announce_r),
    .speed_cap_r(speed_cap_r), .drive_en_r(drive_en_r), .weapon_en_r(weapon_en_r), .destroyed_r(destroyed_r),
    .invuln_r(invuln_r), .impact_r(impact_r), .explode_r(explode_r), .fanfare_r(fanfare_r),
    .reload_done_r(reload_done_r), .ir_tx_r(ir_tx_r), .sensor_led_r(sensor_led_r));
  icsc_ir_sensor_model i_icsc_ir_sensor_model (.clk(clk), .strike(strike), .coded(coded), .ir_any(ir_any),
    .ir_valid(ir_valid));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // ------------------------------------------------
  // Helpers
  // ------------------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic pick(input int sel);
    case (sel)
      0: return weapon_en_r;
      1: return reload_done_r;
      2: return fanfare_r;
      default: return ~invuln_r;
    endcase
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic complete_run();
    if (failures == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Bounded wait; running out of time ends the run
  task automatic wait_sig(input int sel, input int lim, output int n);
    n = 0;
    while (pick(sel) !== 1'b1 && n < lim) begin
      cyc(1);
      n++;
    end
    if (n >= lim) begin
      failures++;
      complete_run();
    end
  endtask
  // Full press and release, both held past the debounce
  task automatic tap(input logic [2:0] nxt);
    notes.push_back({nxt, 6'h20});
    setup_btn = 1'b1;
    cyc(DEB + 6);
    setup_btn = 1'b0;
    cyc(DEB + 6);
  endtask
  task automatic hit(input logic [2:0] md, input logic c, input logic [5:0] e);
    if (e != 6'h00) notes.push_back({md, e});
    strike = 1'b1;
    coded = c;
    cyc(2 + rnd() % 3);
    strike = 1'b0;
    cyc(5 + rnd() % 6);
  endtask
  task automatic pulse_fire();
    fire_req = 1'b1;
    cyc(1);
    fire_req = 1'b0;
  endtask
  // ------------------------------------------------
  // Event monitor: each cycle with any pulse consumes the oldest note
  // ------------------------------------------------
  always @(negedge clk) begin
    ev = {announce_r, impact_r, explode_r, fanfare_r, reload_done_r, ir_tx_r};
    if (rstn && ev != 6'h00) begin
      if (notes.size() == 0) `CHK(ev, 6'h00)
      else begin
        expv = notes.pop_front();
        t_ev = $time;
        `CHK({mode_r, ev}, expv)
      end
    end
  end
  // ------------------------------------------------
  // Main sequence, settings in tap order
  // ------------------------------------------------
  initial begin
    strong_t = '{`ICSC_STRONG_LIGHT, `ICSC_STRONG_MIDDLE, `ICSC_STRONG_HEAVY, `ICSC_STRONG_TEST};
    dest_t = '{`ICSC_DEST_LIGHT, `ICSC_DEST_MIDDLE, `ICSC_DEST_HEAVY, `ICSC_DEST_TEST};
    reload_t = '{`ICSC_RELOAD_LIGHT, `ICSC_RELOAD_MIDDLE, `ICSC_RELOAD_HEAVY, `ICSC_RELOAD_TEST};
    resur_t = '{`ICSC_RESUR_LIGHT, `ICSC_RESUR_MIDDLE, `ICSC_RESUR_HEAVY, `ICSC_RESUR_TEST};
    invul_t = '{`ICSC_INVUL_LIGHT, `ICSC_INVUL_MIDDLE, `ICSC_INVUL_HEAVY, `ICSC_INVUL_TEST};
    seed = 32'hBE7C0ECF;
    {rstn, setup_btn, fire_req, strike, coded} = 5'h00;
    cyc(4);
    rstn = 1'b1;
    b = 0;
    repeat (2 * SEC) begin
      prev = sensor_led_r;
      cyc(1);
      if (sensor_led_r === 1'b1 && prev === 1'b0) b++;
    end
    `CHK(b, `ICSC_BLINK_LIGHT)
    for (m = 0; m < 4; m++) begin
      // Shot, then a second request that lands inside the reload
      notes.push_back({m[2:0], 6'h01});
      notes.push_back({m[2:0], 6'h02});
      wait_sig(0, 400, k);
      pulse_fire();
      cyc(2);
      pulse_fire();
      wait_sig(1, 400, k);
      `CHK(k + 4, reload_t[m] * SEC + 2)
      if (m != 3) hit(m[2:0], 1'b0, 6'h00);
      for (h = 1; h <= dest_t[m]; h++) begin
        hit(m[2:0], m != 3, (h == dest_t[m]) ? 6'h18 : 6'h10);
        `CHK(drive_en_r, 1'b0)
        if (h < dest_t[m]) `CHK(speed_cap_r, (h >= strong_t[m]) ? 2'h2 : 2'h1)
      end
      `CHK(destroyed_r, 1'b1)
      // Explosion time anchors the resurrection delay; one register stage after expiry
      t0 = t_ev;
      hit(m[2:0], 1'b1, 6'h00);
      pulse_fire();
      notes.push_back({m[2:0], 6'h04});
      wait_sig(2, resur_t[m] * SEC + 5, k);
      `CHK(($time - t0) / 20, resur_t[m] * SEC + 1)
      t0 = $time;
      cyc(1);
      `CHK(invuln_r, 1'b1)
      `CHK(speed_cap_r, 2'h0)
      `CHK(drive_en_r, 1'b1)
      hit(m[2:0], 1'b1, 6'h00);
      wait_sig(3, 400, k);
      `CHK(($time - t0) / 20, invul_t[m] * SEC + 1)
      tap(3'(m + 1));
    end
    // Off setting ignores hits and shots
    hit(3'h4, 1'b1, 6'h00);
    pulse_fire();
    cyc(2);
    `CHK(weapon_en_r, 1'b0)
    `CHK(speed_cap_r, 2'h0)
    tap(3'h0);
    cyc(10);
    `CHK(notes.size(), 0)
    complete_run();
  end
endmodule // icsc_core_tb
`default_nettype wire
